// ==== rtl/cpu_bus_pkg.sv ====
// Constants and carrier types for the processor bus buffer and strobe logic
package cpu_bus_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int STROBE_W = 4;
    // Address sections repeat as a four-line then a two-line group
    localparam int GRP_WIDE_W = 4;
    localparam int GRP_NARROW_W = 2;
    localparam int GRP_PAIR_W = GRP_WIDE_W + GRP_NARROW_W;
    localparam int NUM_ADDR_GRP = 5;
    // Bit positions of the combined strobes in strobe_t
    localparam int STB_MEM_RD_POS = 3;
    localparam int STB_MEM_WR_POS = 2;
    localparam int STB_IO_OUT_POS = 1;
    localparam int STB_IO_IN_POS = 0;

    // Processor control outputs, all active low
    typedef struct packed {
        logic mem_request_n;
        logic io_request_n;
        logic rd_n;
        logic wr_n;
    } cpu_ctl_t;

    // Combined strobes toward the shared bus, all active low
    typedef struct packed {
        logic mem_rd_n;
        logic mem_wr_n;
        logic io_out_n;
        logic io_in_n;
    } strobe_t;

endpackage : cpu_bus_pkg

// ==== rtl/tri_group_buffer.sv ====
// One tri-state buffer section with a single shared active-low enable
`timescale 1ns/100ps
module tri_group_buffer #(
    parameter int W = 4
) (
    input wire logic en_n_i,
    input wire logic [W-1:0] a_i,
    output logic [W-1:0] y_o,
    output logic [W-1:0] oe_o
);

    // Data held at zero while floating so no stale value leaks out
    always_comb begin
        y_o = en_n_i ? '0 : a_i;
        oe_o = {W{~en_n_i}};
    end

endmodule : tri_group_buffer

// ==== rtl/cpu_bus_buffer.sv ====
// Processor-to-system-bus buffers, data direction steering and strobes
`timescale 1ns/100ps
module cpu_bus_buffer
    import cpu_bus_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic bus_isolate_n_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire cpu_ctl_t cpu_ctl_i,
    input wire logic [DATA_W-1:0] cpu_dout_i,
    input wire logic [DATA_W-1:0] sys_data_i,
    output logic bus_drive_en_n_o,
    output logic [ADDR_W-1:0] sys_addr_o,
    output logic [ADDR_W-1:0] sys_addr_oe_o,
    output logic data_out_drive_n_o,
    output logic data_in_drive_n_o,
    output logic [DATA_W-1:0] sys_data_o,
    output logic [DATA_W-1:0] sys_data_oe_o,
    output logic [DATA_W-1:0] cpu_din_o,
    output logic [DATA_W-1:0] cpu_din_oe_o,
    output strobe_t strobe_o,
    output logic [STROBE_W-1:0] strobe_oe_o
);

    // Everything here is gates only: a flop in the path would add a cycle
    // between the processor pins and the bus, which the bus cannot absorb.
    logic drive_en_n;
    logic dir_node;
    strobe_t strobe_raw;

    always_comb begin
        drive_en_n = ~bus_isolate_n_i;
        // Isolate forces input direction; else read output picks it
        dir_node = drive_en_n | ~cpu_ctl_i.rd_n;
        bus_drive_en_n_o = drive_en_n;
        data_out_drive_n_o = dir_node;
        data_in_drive_n_o = ~dir_node;
    end

    // Strobes are levels that stand as long as the processor holds its pins
    always_comb begin
        strobe_raw.mem_rd_n = cpu_ctl_i.mem_request_n | cpu_ctl_i.rd_n;
        strobe_raw.mem_wr_n = cpu_ctl_i.mem_request_n | cpu_ctl_i.wr_n;
        strobe_raw.io_out_n = cpu_ctl_i.wr_n | cpu_ctl_i.io_request_n;
        strobe_raw.io_in_n = cpu_ctl_i.rd_n | cpu_ctl_i.io_request_n;
    end

    // Address sections: even index is a four-line group, odd a two-line one
    genvar g;
    generate
        for (g = 0; g < NUM_ADDR_GRP; g++) begin : g_addr
            localparam int W = (g % 2 == 0) ? GRP_WIDE_W : GRP_NARROW_W;
            localparam int LO = (g / 2) * GRP_PAIR_W + (g % 2) * GRP_WIDE_W;
            // One-way buffer, processor side to bus side only
            tri_group_buffer #(.W(W)) u_grp (
                .en_n_i(drive_en_n),
                .a_i(cpu_addr_i[LO +: W]),
                .y_o(sys_addr_o[LO +: W]),
                .oe_o(sys_addr_oe_o[LO +: W])
            );

            // A section shares one enable pin, so it can never split
            chk_group_uniform: assert property (
                @(posedge mclk_i) disable iff (srst_i)
                (sys_addr_oe_o[LO +: W] == '0) ||
                (sys_addr_oe_o[LO +: W] == '1))
                else $error("address section enables split");

            chk_group_follows: assert property (
                @(posedge mclk_i) disable iff (srst_i)
                sys_addr_o[LO +: W] ==
                    (bus_isolate_n_i ? cpu_addr_i[LO +: W] : '0))
                else $error("address section output wrong");
        end
    endgenerate

    // Per address line: each enable is the inverse of the shared active-low drive enable
    genvar a;
    generate
        for (a = 0; a < ADDR_W; a++) begin : g_addr_chk
            chk_addr_line_oe: assert property (
                @(posedge mclk_i) disable iff (srst_i)
                sys_addr_oe_o[a] == !bus_drive_en_n_o)
                else $error("address line enable wrong");
        end
    endgenerate

    // Head-to-toe data sets; the direction node keeps them exclusive
    tri_group_buffer #(.W(DATA_W)) u_data_out (
        .en_n_i(dir_node),
        .a_i(cpu_dout_i),
        .y_o(sys_data_o),
        .oe_o(sys_data_oe_o)
    );

    tri_group_buffer #(.W(DATA_W)) u_data_in (
        .en_n_i(~dir_node),
        .a_i(sys_data_i),
        .y_o(cpu_din_o),
        .oe_o(cpu_din_oe_o)
    );

    tri_group_buffer #(.W(STROBE_W)) u_strobe (
        .en_n_i(drive_en_n),
        .a_i(strobe_raw),
        .y_o(strobe_o),
        .oe_o(strobe_oe_o)
    );

    // Per data line: exactly one of the two opposed buffers is on, since
    // both on would short the line and both off would leave it floating
    genvar b;
    generate
        for (b = 0; b < DATA_W; b++) begin : g_data_chk
            chk_line_exclusive: assert property (
                @(posedge mclk_i) disable iff (srst_i)
                !(sys_data_oe_o[b] && cpu_din_oe_o[b]))
                else $error("data line driven both ways");

            chk_line_one_on: assert property (
                @(posedge mclk_i) disable iff (srst_i)
                sys_data_oe_o[b] != cpu_din_oe_o[b])
                else $error("data line has no buffer on");
        end
    endgenerate

    // Per strobe line: tri-stated exactly like the address lines
    genvar s;
    generate
        for (s = 0; s < STROBE_W; s++) begin : g_strobe_chk
            chk_strobe_line_oe: assert property (
                @(posedge mclk_i) disable iff (srst_i)
                strobe_oe_o[s] == !bus_drive_en_n_o)
                else $error("strobe line enable wrong");
        end
    endgenerate

    // Checks, sampled on the system clock although the logic is clockless
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    chk_addr_one_way: assert property (
        bus_isolate_n_i |-> sys_addr_o == cpu_addr_i)
        else $error("address not passed toward bus");

    chk_addr_groups_float: assert property (
        !bus_isolate_n_i |-> sys_addr_oe_o == '0)
        else $error("an address group still drives while isolated");

    chk_addr_drive_whole: assert property (
        bus_isolate_n_i |-> (&sys_addr_oe_o) && !bus_drive_en_n_o)
        else $error("address groups not all driving while enabled");

    chk_enable_inverse: assert property (
        bus_drive_en_n_o == !bus_isolate_n_i)
        else $error("drive enable not inverse of isolate");

    chk_data_sets_pass: assert property (
        (!data_out_drive_n_o |-> sys_data_o == cpu_dout_i) and
        (!data_in_drive_n_o |-> cpu_din_o == sys_data_i))
        else $error("data set does not pass its input");

    chk_data_exclusive: assert property (
        (data_out_drive_n_o != data_in_drive_n_o) &&
        !((|sys_data_oe_o) && (|cpu_din_oe_o)))
        else $error("both data sets enabled");

    chk_isolate_dir: assert property (
        !bus_isolate_n_i |-> data_out_drive_n_o && !data_in_drive_n_o
            && (cpu_din_oe_o == '1))
        else $error("isolate did not force input direction");

    chk_read_dir: assert property (
        bus_isolate_n_i |->
            (data_out_drive_n_o == !cpu_ctl_i.rd_n) &&
            (sys_data_oe_o == {DATA_W{cpu_ctl_i.rd_n}}))
        else $error("direction does not follow read output");

    chk_mem_rd_strobe: assert property (
        bus_isolate_n_i |-> strobe_o.mem_rd_n ==
            (cpu_ctl_i.mem_request_n | cpu_ctl_i.rd_n))
        else $error("memory read strobe wrong");

    chk_mem_wr_strobe: assert property (
        bus_isolate_n_i |-> strobe_o.mem_wr_n ==
            (cpu_ctl_i.mem_request_n | cpu_ctl_i.wr_n))
        else $error("memory write strobe wrong");

    chk_io_out_strobe: assert property (
        bus_isolate_n_i |-> strobe_o.io_out_n ==
            (cpu_ctl_i.wr_n | cpu_ctl_i.io_request_n))
        else $error("I/O output strobe wrong");

    chk_io_in_strobe: assert property (
        bus_isolate_n_i |-> strobe_o.io_in_n ==
            (cpu_ctl_i.rd_n | cpu_ctl_i.io_request_n))
        else $error("I/O input strobe wrong");

    chk_strobe_tristate: assert property (
        strobe_oe_o == {STROBE_W{sys_addr_oe_o[0]}} &&
        strobe_oe_o == {STROBE_W{sys_addr_oe_o[ADDR_W-1]}})
        else $error("strobe enables differ from address enables");

    chk_no_latency: assert property (
        $changed(bus_isolate_n_i) |->
            (sys_addr_oe_o[0] == bus_isolate_n_i) &&
            ($past(sys_addr_oe_o[0]) != sys_addr_oe_o[0]))
        else $error("enable lags the isolate input");

    chk_addr_float_zero: assert property (
        !bus_isolate_n_i |-> sys_addr_o == '0)
        else $error("floating address does not read zero");

    chk_strobe_float: assert property (
        !bus_isolate_n_i |-> (strobe_oe_o == '0) && (strobe_o == '0))
        else $error("strobes still driven while isolated");

    // A combined strobe goes low only for its own two inputs
    chk_mem_rd_only: assert property (
        strobe_oe_o[STB_MEM_RD_POS] && !strobe_o.mem_rd_n |->
            !cpu_ctl_i.mem_request_n && !cpu_ctl_i.rd_n)
        else $error("memory read strobe without its inputs");

    chk_mem_wr_only: assert property (
        strobe_oe_o[STB_MEM_WR_POS] && !strobe_o.mem_wr_n |->
            !cpu_ctl_i.mem_request_n && !cpu_ctl_i.wr_n)
        else $error("memory write strobe without its inputs");

    chk_io_out_only: assert property (
        strobe_oe_o[STB_IO_OUT_POS] && !strobe_o.io_out_n |->
            !cpu_ctl_i.wr_n && !cpu_ctl_i.io_request_n)
        else $error("I/O output strobe without its inputs");

    chk_io_in_only: assert property (
        strobe_oe_o[STB_IO_IN_POS] && !strobe_o.io_in_n |->
            !cpu_ctl_i.rd_n && !cpu_ctl_i.io_request_n)
        else $error("I/O input strobe without its inputs");

    chk_read_keeps_addr: assert property (
        bus_isolate_n_i && !cpu_ctl_i.rd_n |->
            !data_in_drive_n_o && (&sys_addr_oe_o))
        else $error("read lost the address drive");

    chk_write_out_set: assert property (
        bus_isolate_n_i && cpu_ctl_i.rd_n |->
            (sys_data_o == cpu_dout_i) && (cpu_din_oe_o == '0))
        else $error("output set not alone while read output high");

    chk_read_no_lag: assert property (
        bus_isolate_n_i && $past(bus_isolate_n_i) &&
            $changed(cpu_ctl_i.rd_n) |->
            $changed(data_out_drive_n_o) && $changed(data_in_drive_n_o))
        else $error("direction lags the read output");

    chk_addr_no_lag: assert property (
        bus_isolate_n_i && $past(bus_isolate_n_i) &&
            $changed(cpu_addr_i) |->
            $changed(sys_addr_o))
        else $error("address lags the processor");

    chk_dout_no_lag: assert property (
        !data_out_drive_n_o && !$past(data_out_drive_n_o) &&
            $changed(cpu_dout_i) |->
            $changed(sys_data_o))
        else $error("output data lags the processor");

    chk_din_no_lag: assert property (
        !data_in_drive_n_o && !$past(data_in_drive_n_o) &&
            $changed(sys_data_i) |->
            $changed(cpu_din_o))
        else $error("input data lags the bus");

    chk_isolate_input_set: assert property (
        !bus_isolate_n_i |-> (cpu_din_o == sys_data_i) &&
            (sys_data_oe_o == '0) && (sys_data_o == '0))
        else $error("input set not alone while isolated");

    // Off buffers read zero so a bench can tell floating from driving
    chk_out_set_off_zero: assert property (
        data_out_drive_n_o |-> sys_data_o == '0)
        else $error("disabled output set not zero");

    chk_in_set_off_zero: assert property (
        data_in_drive_n_o |-> cpu_din_o == '0)
        else $error("disabled input set not zero");

    cov_mem_read: cover property (
        bus_isolate_n_i && !strobe_o.mem_rd_n && cpu_din_oe_o[0]);
    cov_mem_write: cover property (
        bus_isolate_n_i && !strobe_o.mem_wr_n && sys_data_oe_o[0]);
    cov_io_cycle: cover property (
        bus_isolate_n_i && (!strobe_o.io_in_n || !strobe_o.io_out_n));
    cov_isolate: cover property (
        bus_isolate_n_i ##1 !bus_isolate_n_i [*2] ##1 bus_isolate_n_i);
    cov_write_then_read: cover property (
        !strobe_o.mem_wr_n && strobe_oe_o[STB_MEM_WR_POS] ##1
        !strobe_o.mem_rd_n && strobe_oe_o[STB_MEM_RD_POS]);

endmodule : cpu_bus_buffer

// ==== tb/bus_far_model.sv ====
// Far-side bus responder that feeds read data toward the processor
`timescale 1ns/100ps
module bus_far_model
    import cpu_bus_pkg::*;
(
    input wire logic mclk_i,
    input wire logic data_in_drive_n_i,
    input wire logic [DATA_W-1:0] fresh_i,
    output logic [DATA_W-1:0] sys_data_o
);
    initial sys_data_o = 8'h5a;
    // Unselected bus shows the inverse of its last value, never a stale hold
    always @(posedge mclk_i) begin
        if (!data_in_drive_n_i) begin
            sys_data_o <= fresh_i;
        end else begin
            sys_data_o <= ~sys_data_o;
        end
    end
endmodule : bus_far_model

// ==== tb/cpu_bus_buffer_strobe_logic_tb.sv ====
// Self-checking bench for the bus buffer, steering and strobe logic
`timescale 1ns/100ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin \
    bad_count++; $display("MISMATCH %0t %s", $time, m); end end
module cpu_bus_buffer_strobe_logic_tb;
    import cpu_bus_pkg::*;
    typedef struct packed {
        logic en_n; logic [15:0] addr; logic [15:0] aoe;
        logic dout_n; logic din_n; logic [7:0] sd; logic [7:0] sdoe;
        logic [7:0] din; logic [7:0] dinoe; strobe_t stb; logic [3:0] soe;
    } exp_t;
    logic mclk_i = 1'b0, srst_i = 1'b1, iso_n = 1'b1;
    logic [15:0] addr = 16'h0000;
    cpu_ctl_t ctl = 4'hf;
    logic [7:0] dout = 8'h00, fresh = 8'h00, sys_data_i;
    exp_t obs, e;
    exp_t expq[$];
    int bad_count = 0, comparisons = 0, k;
    initial forever #10 mclk_i = ~mclk_i;
    cpu_bus_buffer cpu_bus_buffer_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .bus_isolate_n_i(iso_n), .cpu_addr_i(addr), .cpu_ctl_i(ctl),
        .cpu_dout_i(dout), .sys_data_i(sys_data_i),
        .bus_drive_en_n_o(obs.en_n), .sys_addr_o(obs.addr),
        .sys_addr_oe_o(obs.aoe), .data_out_drive_n_o(obs.dout_n),
        .data_in_drive_n_o(obs.din_n), .sys_data_o(obs.sd),
        .sys_data_oe_o(obs.sdoe), .cpu_din_o(obs.din),
        .cpu_din_oe_o(obs.dinoe), .strobe_o(obs.stb), .strobe_oe_o(obs.soe));
    bus_far_model bus_far_model_i (.mclk_i(mclk_i),
        .data_in_drive_n_i(obs.din_n), .fresh_i(fresh),
        .sys_data_o(sys_data_i));
    function automatic exp_t predict(logic i, logic [15:0] a, cpu_ctl_t c,
                                     logic [7:0] d, logic [7:0] s);
        exp_t x;
        logic dir;
        dir = ~i | ~c.rd_n;
        x.en_n = ~i;
        x.aoe = i ? 16'hffff : 16'h0000;
        x.addr = i ? a : 16'h0000;
        x.dout_n = dir;
        x.din_n = ~dir;
        x.sdoe = dir ? 8'h00 : 8'hff;
        x.sd = dir ? 8'h00 : d;
        x.dinoe = dir ? 8'hff : 8'h00;
        x.din = dir ? s : 8'h00;
        x.stb = i ? {c.mem_request_n | c.rd_n, c.mem_request_n | c.wr_n,
                     c.wr_n | c.io_request_n, c.rd_n | c.io_request_n} : 4'h0;
        x.soe = i ? 4'hf : 4'h0;
        return x;
    endfunction : predict
    task automatic apply(logic i, logic [15:0] a, logic [3:0] c, logic [7:0] d);
        @(negedge mclk_i);
        iso_n = i;
        addr = a;
        ctl = c;
        dout = d;
        fresh = $urandom;
        expq.push_back(predict(i, a, c, d, sys_data_i));
    endtask : apply
    // Same-cycle compare: any added latency shows as a mismatch
    initial forever begin
        @(posedge mclk_i);
        if (expq.size() > 0) begin
            e = expq.pop_front();
            `CHK(obs.en_n, e.en_n, "drive enable")
            `CHK(obs.addr, e.addr, "address")
            `CHK(obs.aoe, e.aoe, "address enable")
            `CHK({obs.dout_n, obs.din_n}, {e.dout_n, e.din_n}, "dir")
            `CHK({obs.sd, obs.sdoe}, {e.sd, e.sdoe}, "data out")
            `CHK({obs.din, obs.dinoe}, {e.din, e.dinoe}, "data in")
            `CHK(obs.stb, e.stb, "strobes")
            `CHK(obs.soe, e.soe, "strobe enable")
        end
    end
    task automatic close_out();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    initial begin
        void'($urandom(23));
        repeat (5) @(negedge mclk_i);
        srst_i = 1'b0;
        for (k = 0; k < 32; k++) begin
            apply(k[4], $urandom, k[3:0], $urandom);
        end
        $display("test control_walk done");
        repeat (300) apply(($urandom % 4) != 0, $urandom, $urandom, $urandom);
        $display("test random_mix done");
        // Outputs must keep following inputs while the reset is high
        @(negedge mclk_i);
        srst_i = 1'b1;
        repeat (4) apply($urandom, $urandom, $urandom, $urandom);
        srst_i = 1'b0;
        repeat (4) apply(1'b1, $urandom, $urandom, $urandom);
        $display("test reset_mid_run done");
        for (k = 0; k < 10 && expq.size() > 0; k++) @(posedge mclk_i);
        if (expq.size() > 0) begin
            bad_count++;
        end
        close_out();
    end
endmodule : cpu_bus_buffer_strobe_logic_tb
